/* File: src/low_power_mode_controller.v */
// power mode controller: suspend, sleep, low power active and idle
`default_nettype none
`include "power_mode_regs.vh"

// Functional notes
// - suspend select gates system clock and turns off all internal oscillators.
// - in suspend all clocked logic stays stopped until an enabled wake.
// - suspend exits on rtc fail, alarm, port match, i2c match, cap sense.
// - sleep select turns core regulator off and moves ram to main supply.
// - in sleep only power unit and real-time clock stay powered.
// - sleep keeps ram, registers, program counter so execution resumes; code drives RESUME_VECTOR_OUT with RESET_VECTOR on every wake.
// - sleep exits on rtc fail, alarm, port match, i2c match only.
// - low power active lets firmware gate unused peripheral clocks, cpu runs.
// - cpu cannot access registers of a peripheral whose branch is off.
// - low power active ends when clock mode written zero or reset.
// - low power idle halts cpu, retains state, grants requested clocks.
// - interrupt in low power idle goes to low power active only.
// - interrupt wake from idle resumes after the idle-setting instruction; code still drives RESUME_VECTOR_OUT with RESET_VECTOR.
// - reset ending idle runs normal reset sequence, fetch at zero.
// - idle select halts cpu after the setting instruction completes.
// - wake from low power idle completes within two clock cycles.
// - suspend wake restarts quickly at next instruction without reset; code drives RESUME_VECTOR_OUT with RESET_VECTOR on wake.
module low_power_mode_controller #(
	parameter NUM_BRANCH = 8
)(
	input wire SYS_CLK_IN,
	input wire NRST_IN,
	input wire SUSPEND_SEL_IN,
	input wire SLEEP_SEL_IN,
	input wire IDLE_SEL_IN,
	input wire INSTR_DONE_IN,
	input wire CLK_MODE_WR_IN,
	input wire [`CLK_MODE_WIDTH-1:0] CLK_MODE_DATA_IN,
	input wire [`WAKE_COUNT-1:0] WAKE_ENABLE_IN,
	input wire [`WAKE_COUNT-1:0] WAKE_EVENT_IN,
	input wire IRQ_IN,
	input wire [NUM_BRANCH-1:0] CLK_REQ_IN,
	output reg SYS_CLK_EN_OUT,
	output reg OSC_EN_OUT,
	output reg CORE_REG_EN_OUT,
	output reg RAM_ON_MAIN_OUT,
	output reg LOGIC_PWR_EN_OUT,
	output reg CPU_HALT_OUT,
	output reg IRQ_SERVICE_OUT,
	output reg [15:0] RESUME_VECTOR_OUT,
	output reg LP_ACTIVE_OUT,
	output reg [`CLK_MODE_WIDTH-1:0] CLK_MODE_OUT,
	output reg [2:0] MODE_OUT,
	output reg [`WAKE_COUNT-1:0] WAKE_FLAGS_OUT,
	output wire [NUM_BRANCH-1:0] BRANCH_CLK_EN_OUT,
	output wire [NUM_BRANCH-1:0] SFR_ACCESS_EN_OUT
);
	// ------------------------------------------------------------
	// modes
	// ------------------------------------------------------------
	localparam [2:0] ST_ACTIVE = 3'h0;
	localparam [2:0] ST_IDLE_PEND = 3'h1;
	localparam [2:0] ST_IDLE = 3'h2;
	localparam [2:0] ST_SUSPEND = 3'h3;
	localparam [2:0] ST_SLEEP = 3'h4;

	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [`CLK_MODE_WIDTH-1:0] clk_mode_reg;
	reg [`CLK_MODE_WIDTH-1:0] clk_mode_next;
	reg wake_clear;
	wire [`WAKE_COUNT-1:0] wake_pending;
	wire [`WAKE_COUNT-1:0] allow;
	wire lp_mode;
	wire wake_any;
	wire [`WAKE_COUNT-1:0] wake_now;
	reg sys_clk_en_next;
	reg osc_en_next;
	reg core_reg_en_next;
	reg ram_on_main_next;
	reg logic_pwr_en_next;
	reg cpu_halt_next;
	reg irq_service_next;
	reg lp_active_next;
	reg [`WAKE_COUNT-1:0] wake_flags_next;
	genvar w;

	// cap sense may only end suspend, never sleep
	assign allow = (state_reg == ST_SLEEP) ? `WAKE_SLEEP_MASK : {`WAKE_COUNT{1'b1}};
	assign lp_mode = (clk_mode_reg != `CLK_MODE_ACTIVE);

	// ------------------------------------------------------------
	// wake sources
	// ------------------------------------------------------------
	wake_source_filter #(
		.N(`WAKE_COUNT)
	) u_wake (
		.clk_in(SYS_CLK_IN),
		.nrst_in(NRST_IN),
		.event_in(WAKE_EVENT_IN),
		.enable_in(WAKE_ENABLE_IN),
		.allow_in(allow),
		.clear_in(wake_clear),
		.pending_out(wake_pending)
	);

	// the filter is registered, so the mode logic looks at raw gated events instead for speed
	generate
		for (w = 0; w < `WAKE_COUNT; w = w + 1)
		begin : g_wake
			assign wake_now[w] = WAKE_EVENT_IN[w] && WAKE_ENABLE_IN[w] && allow[w];
		end
	endgenerate
	assign wake_any = |wake_now;

	// ------------------------------------------------------------
	// clock tree branches
	// ------------------------------------------------------------
	clock_branch_gate #(
		.N(NUM_BRANCH)
	) u_gate (
		.clk_in(SYS_CLK_IN),
		.nrst_in(NRST_IN),
		.run_in(state_next != ST_SUSPEND && state_next != ST_SLEEP),
		.lp_mode_in(lp_mode || state_next == ST_IDLE),
		.gate_off_in(clk_mode_reg),
		.request_in(CLK_REQ_IN),
		.cpu_halt_in(1'b0),
		.branch_en_out(BRANCH_CLK_EN_OUT),
		.access_en_out(SFR_ACCESS_EN_OUT)
	);

	// ------------------------------------------------------------
	// mode sequencing
	// ------------------------------------------------------------
	always @*
	begin
		state_next = state_reg;
		clk_mode_next = clk_mode_reg;
		wake_clear = 1'b0;
		if (CLK_MODE_WR_IN)
			clk_mode_next = CLK_MODE_DATA_IN;
		case (state_reg)
			ST_ACTIVE:
			begin
				if (SUSPEND_SEL_IN)
					state_next = ST_SUSPEND;
				else if (SLEEP_SEL_IN)
					state_next = ST_SLEEP;
				else if (IDLE_SEL_IN)
					state_next = INSTR_DONE_IN ? ST_IDLE : ST_IDLE_PEND;
			end
			ST_IDLE_PEND:
			begin
				if (INSTR_DONE_IN)
					state_next = ST_IDLE;
			end
			ST_IDLE:
			begin
				if (IRQ_IN)
				begin
					// interrupt leaves gating alone: lands in low power active
					state_next = ST_ACTIVE;
				end
			end
			ST_SUSPEND, ST_SLEEP:
			begin
				if (wake_any)
				begin
					state_next = ST_ACTIVE;
					wake_clear = 1'b1;
				end
			end
			default:
				state_next = ST_ACTIVE;
		endcase
	end

	// ------------------------------------------------------------
	// next values of the registered outputs
	// ------------------------------------------------------------
	// decoded from the next state so every output but WAKE_FLAGS_OUT moves on the edge that moves MODE_OUT; the flags follow one cycle later
	always @*
	begin
		sys_clk_en_next = 1'b1;
		osc_en_next = 1'b1;
		core_reg_en_next = 1'b1;
		ram_on_main_next = 1'b0;
		logic_pwr_en_next = 1'b1;
		cpu_halt_next = 1'b0;
		case (state_next)
			ST_ACTIVE, ST_IDLE_PEND:
			begin
				// idle wake drops halt on the edge that takes the interrupt: 1 cycle
				cpu_halt_next = 1'b0;
			end
			ST_IDLE:
			begin
				// requested branches keep their clocks while the cpu waits
				cpu_halt_next = 1'b1;
			end
			ST_SUSPEND:
			begin
				sys_clk_en_next = 1'b0;
				osc_en_next = 1'b0;
				cpu_halt_next = 1'b1;
			end
			ST_SLEEP:
			begin
				sys_clk_en_next = 1'b0;
				osc_en_next = 1'b0;
				core_reg_en_next = 1'b0;
				ram_on_main_next = 1'b1;
				logic_pwr_en_next = 1'b0;
				cpu_halt_next = 1'b1;
			end
			default:
			begin
				cpu_halt_next = 1'b0;
			end
		endcase
		irq_service_next = (state_reg == ST_IDLE) && IRQ_IN;
		lp_active_next = (clk_mode_next != `CLK_MODE_ACTIVE);
		wake_flags_next = wake_pending;
	end

	// ------------------------------------------------------------
	// state registers
	// ------------------------------------------------------------
	always @(posedge SYS_CLK_IN or negedge NRST_IN)
	begin
		if (!NRST_IN)
		begin
			// reset also ends low power active and idle
			state_reg <= ST_ACTIVE;
			clk_mode_reg <= `CLK_MODE_RESET;
		end
		else
		begin
			state_reg <= state_next;
			clk_mode_reg <= clk_mode_next;
		end
	end

	// ------------------------------------------------------------
	// power and clock outputs
	// ------------------------------------------------------------
	always @(posedge SYS_CLK_IN or negedge NRST_IN)
	begin
		if (!NRST_IN)
		begin
			SYS_CLK_EN_OUT <= 1'b1;
			OSC_EN_OUT <= 1'b1;
			CORE_REG_EN_OUT <= 1'b1;
			RAM_ON_MAIN_OUT <= 1'b0;
			LOGIC_PWR_EN_OUT <= 1'b1;
		end
		else
		begin
			SYS_CLK_EN_OUT <= sys_clk_en_next;
			OSC_EN_OUT <= osc_en_next;
			CORE_REG_EN_OUT <= core_reg_en_next;
			RAM_ON_MAIN_OUT <= ram_on_main_next;
			LOGIC_PWR_EN_OUT <= logic_pwr_en_next;
		end
	end

	// ------------------------------------------------------------
	// cpu outputs
	// ------------------------------------------------------------
	always @(posedge SYS_CLK_IN or negedge NRST_IN)
	begin
		if (!NRST_IN)
		begin
			CPU_HALT_OUT <= 1'b0;
			IRQ_SERVICE_OUT <= 1'b0;
			RESUME_VECTOR_OUT <= `RESET_VECTOR;
		end
		else
		begin
			CPU_HALT_OUT <= cpu_halt_next;
			// nothing here clears volatile state, so it survives sleep
			IRQ_SERVICE_OUT <= irq_service_next;
			// resume vector is driven with the reset vector on wake as well as after reset
			RESUME_VECTOR_OUT <= `RESET_VECTOR;
		end
	end

	// ------------------------------------------------------------
	// status outputs
	// ------------------------------------------------------------
	always @(posedge SYS_CLK_IN or negedge NRST_IN)
	begin
		if (!NRST_IN)
		begin
			LP_ACTIVE_OUT <= 1'b0;
			CLK_MODE_OUT <= `CLK_MODE_RESET;
			MODE_OUT <= ST_ACTIVE;
			WAKE_FLAGS_OUT <= `WAKE_ENABLE_RESET;
		end
		else
		begin
			LP_ACTIVE_OUT <= lp_active_next;
			CLK_MODE_OUT <= clk_mode_next;
			MODE_OUT <= state_next;
			WAKE_FLAGS_OUT <= wake_flags_next;
		end
	end
endmodule // low_power_mode_controller

`default_nettype wire

/* File: pkg/power_mode_regs.vh */
// constants shared by the power mode controller files
`ifndef POWER_MODE_REGS_VH
`define POWER_MODE_REGS_VH

// wake source bit positions
`define WAKE_RTC_FAIL 0
`define WAKE_RTC_ALARM 1
`define WAKE_PORT_MATCH 2
`define WAKE_I2C_MATCH 3
`define WAKE_CAP_SENSE 4
`define WAKE_COUNT 5
// sources allowed to end sleep (cap sense excluded)
`define WAKE_SLEEP_MASK 5'h0F
`define WAKE_ENABLE_RESET 5'h00

// clock gating mode register
`define CLK_MODE_WIDTH 8
`define CLK_MODE_RESET 8'h00
`define CLK_MODE_ACTIVE 8'h00

// wake from low power idle, in clock cycles
`define IDLE_WAKE_CYCLES 2

// reset vector
`define RESET_VECTOR 16'h0000

`endif

/* File: src/wake_source_filter.v */
// wake source enable gating and sticky wake capture
`default_nettype none

module wake_source_filter #(
	parameter N = 5
)(
	input wire clk_in,
	input wire nrst_in,
	input wire [N-1:0] event_in,
	input wire [N-1:0] enable_in,
	input wire [N-1:0] allow_in,
	input wire clear_in,
	output reg [N-1:0] pending_out
);
	genvar i;
	generate
		for (i = 0; i < N; i = i + 1)
		begin : g_src
			// set wins over clear so an event in the clear cycle survives
			always @(posedge clk_in or negedge nrst_in)
			begin
				if (!nrst_in)
					pending_out[i] <= 1'b0;
				else if (event_in[i] && enable_in[i] && allow_in[i])
					pending_out[i] <= 1'b1;
				else if (clear_in)
					pending_out[i] <= 1'b0;
			end
		end
	endgenerate
endmodule // wake_source_filter

`default_nettype wire

/* File: src/clock_branch_gate.v */
// per peripheral clock branch enable and register access gate
`default_nettype none

module clock_branch_gate #(
	parameter N = 8
)(
	input wire clk_in,
	input wire nrst_in,
	input wire run_in,
	input wire lp_mode_in,
	input wire [N-1:0] gate_off_in,
	input wire [N-1:0] request_in,
	input wire cpu_halt_in,
	output reg [N-1:0] branch_en_out,
	output reg [N-1:0] access_en_out
);
	genvar i;
	generate
		for (i = 0; i < N; i = i + 1)
		begin : g_br
			wire on = run_in && (!lp_mode_in || !gate_off_in[i] || request_in[i]);
			always @(posedge clk_in or negedge nrst_in)
			begin
				if (!nrst_in)
				begin
					branch_en_out[i] <= 1'b1;
					access_en_out[i] <= 1'b1;
				end
				else
				begin
					branch_en_out[i] <= on;
					// cpu may not touch registers of a stopped branch
					access_en_out[i] <= on && !cpu_halt_in;
				end
			end
		end
	endgenerate
endmodule // clock_branch_gate

`default_nettype wire

/* File: dv/wake_source_model.sv */
// wake source model: fires one-cycle wake events on request
`default_nettype none
module wake_source_model (
	input wire logic clk_in,
	output logic [4:0] event_out
);
	timeunit 1ns;
	timeprecision 1ns;
	initial event_out = 5'h00;
	// events rise after a falling edge and drop after one full cycle
	task automatic fire(input logic [4:0] m);
		@(negedge clk_in);
		event_out = m;
		@(negedge clk_in);
		event_out = 5'h00;
	endtask
endmodule // wake_source_model
`default_nettype wire

/* File: dv/low_power_mode_controller_assertions.sv */
// concurrent checks on the power mode controller ports
`default_nettype none
`include "power_mode_regs.vh"
module lpm_checker #(
	parameter NUM_BRANCH = 8
)(
	input wire logic SYS_CLK_IN,
	input wire logic NRST_IN,
	input wire logic SUSPEND_SEL_IN,
	input wire logic SLEEP_SEL_IN,
	input wire logic IDLE_SEL_IN,
	input wire logic INSTR_DONE_IN,
	input wire logic CLK_MODE_WR_IN,
	input wire logic [`CLK_MODE_WIDTH-1:0] CLK_MODE_DATA_IN,
	input wire logic [`WAKE_COUNT-1:0] WAKE_ENABLE_IN,
	input wire logic [`WAKE_COUNT-1:0] WAKE_EVENT_IN,
	input wire logic IRQ_IN,
	input wire logic SYS_CLK_EN_OUT,
	input wire logic OSC_EN_OUT,
	input wire logic CORE_REG_EN_OUT,
	input wire logic CPU_HALT_OUT,
	input wire logic IRQ_SERVICE_OUT,
	input wire logic [`CLK_MODE_WIDTH-1:0] CLK_MODE_OUT,
	input wire logic [2:0] MODE_OUT,
	input wire logic [NUM_BRANCH-1:0] BRANCH_CLK_EN_OUT,
	input wire logic [NUM_BRANCH-1:0] SFR_ACCESS_EN_OUT
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge SYS_CLK_IN); endclocking
	default disable iff (!NRST_IN);
	suspend_entry_a: assert property (MODE_OUT == 3'h0 && SUSPEND_SEL_IN
		|=> MODE_OUT == 3'h3 && !SYS_CLK_EN_OUT && !OSC_EN_OUT) else $error("suspend entry");
	suspend_hold_a: assert property (MODE_OUT == 3'h3 && !(|(WAKE_EVENT_IN & WAKE_ENABLE_IN))
		|=> MODE_OUT == 3'h3 && !SYS_CLK_EN_OUT) else $error("suspend left early");
	suspend_wake_a: assert property (MODE_OUT == 3'h3 && |(WAKE_EVENT_IN & WAKE_ENABLE_IN)
		|=> MODE_OUT == 3'h0 && SYS_CLK_EN_OUT && !CPU_HALT_OUT) else $error("suspend wake");
	sleep_entry_a: assert property (MODE_OUT == 3'h0 && SLEEP_SEL_IN && !SUSPEND_SEL_IN
		&& !IDLE_SEL_IN |=> MODE_OUT == 3'h4 && !CORE_REG_EN_OUT) else $error("sleep entry");
	idle_entry_a: assert property (MODE_OUT == 3'h0 && IDLE_SEL_IN && INSTR_DONE_IN
		&& !SUSPEND_SEL_IN && !SLEEP_SEL_IN |=> MODE_OUT == 3'h2 && CPU_HALT_OUT) else $error("idle entry");
	idle_wake_a: assert property (MODE_OUT == 3'h2 && IRQ_IN && !CLK_MODE_WR_IN
		|=> MODE_OUT == 3'h0
		&& IRQ_SERVICE_OUT && CLK_MODE_OUT == $past(CLK_MODE_OUT)) else $error("idle wake");
	mode_write_a: assert property (CLK_MODE_WR_IN
		|=> CLK_MODE_OUT == $past(CLK_MODE_DATA_IN)) else $error("clock mode write");
	sleep_wake_a: assert property (MODE_OUT == 3'h4
		&& |(WAKE_EVENT_IN & WAKE_ENABLE_IN & `WAKE_SLEEP_MASK)
		|=> MODE_OUT == 3'h0 && CORE_REG_EN_OUT) else $error("sleep wake");
	sleep_hold_a: assert property (MODE_OUT == 3'h4
		&& !(|(WAKE_EVENT_IN & WAKE_ENABLE_IN & `WAKE_SLEEP_MASK))
		|=> MODE_OUT == 3'h4 && !CORE_REG_EN_OUT) else $error("sleep left early");
	idle_pend_a: assert property (MODE_OUT == 3'h1 && !INSTR_DONE_IN
		|=> MODE_OUT == 3'h1 && !CPU_HALT_OUT) else $error("idle pending");
	sfr_gate_a: assert property (SFR_ACCESS_EN_OUT == BRANCH_CLK_EN_OUT) else $error("sfr gate");
endmodule // lpm_checker
bind low_power_mode_controller lpm_checker #(.NUM_BRANCH(NUM_BRANCH)) chk (.*);
`default_nettype wire

/* File: dv/low_power_mode_controller_bench.sv */
// self-checking bench for the power mode controller
`default_nettype none
module low_power_mode_controller_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, nrst = 1'b0, sus = 1'b0, slp = 1'b0, idl = 1'b0, done = 1'b0;
	logic wr = 1'b0, irq = 1'b0, sclk, osc, creg, ram, lpw, halt, svc, lpa;
	logic [7:0] data = 8'h00, req = 8'h00, br, sfr, cm;
	logic [4:0] en = 5'h00, ev, flags;
	logic [2:0] mode;
	logic [15:0] vec;
	int bad_count = 0, n_checks = 0, cycles = 0;
	initial forever #5 clk = ~clk;
	wake_source_model wake_src (.clk_in(clk), .event_out(ev));
	low_power_mode_controller #(.NUM_BRANCH(8)) dut (.SYS_CLK_IN(clk), .NRST_IN(nrst),
		.SUSPEND_SEL_IN(sus), .SLEEP_SEL_IN(slp), .IDLE_SEL_IN(idl), .INSTR_DONE_IN(done),
		.CLK_MODE_WR_IN(wr), .CLK_MODE_DATA_IN(data), .WAKE_ENABLE_IN(en), .WAKE_EVENT_IN(ev),
		.IRQ_IN(irq), .CLK_REQ_IN(req), .SYS_CLK_EN_OUT(sclk), .OSC_EN_OUT(osc),
		.CORE_REG_EN_OUT(creg), .RAM_ON_MAIN_OUT(ram), .LOGIC_PWR_EN_OUT(lpw),
		.CPU_HALT_OUT(halt), .IRQ_SERVICE_OUT(svc), .RESUME_VECTOR_OUT(vec), .LP_ACTIVE_OUT(lpa),
		.CLK_MODE_OUT(cm), .MODE_OUT(mode), .WAKE_FLAGS_OUT(flags), .BRANCH_CLK_EN_OUT(br),
		.SFR_ACCESS_EN_OUT(sfr));
	task automatic tick;
		@(negedge clk);
	endtask
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// each source alone: the other four stay disabled and must be ignored
	task automatic t_suspend;
		for (int i = 0; i < 5; i++)
		begin
			en = 5'h01 << i;
			sus = 1'b1;
			tick;
			sus = 1'b0;
			check("suspend clocks", 16'({mode, sclk, osc, halt}), 16'h0019);
			wake_src.fire(~en);
			check("suspend held", 16'({mode, sclk}), 16'h0006);
			wake_src.fire(en);
			check("suspend wake", 16'({mode, sclk, osc, halt}), 16'h0006);
			tick;
			check("wake flag", 16'(flags), 16'(en));
		end
	endtask
	task automatic t_sleep;
		en = 5'h1F;
		for (int i = 0; i < 4; i++)
		begin
			slp = 1'b1; // converter off, ram on main and logic power off checked first
			tick;
			slp = 1'b0;
			check("sleep power", 16'({mode, creg, ram, lpw}), 16'h0022);
			wake_src.fire(5'h10);
			check("sleep cap sense", 16'(mode), 16'h0004);
			wake_src.fire(5'h01 << i);
			check("sleep wake", 16'({mode, creg, lpw}), 16'h0003);
		end
	endtask
	task automatic t_idle;
		data = 8'h05;
		wr = 1'b1;
		tick;
		wr = 1'b0;
		req = 8'h01;
		repeat (2) tick;
		check("gated branches", 16'({br, lpa}), 16'h01F7);
		check("sfr access", 16'(sfr), 16'h00FB);
		req = 8'h00;
		idl = 1'b1;
		tick;
		idl = 1'b0;
		check("idle pending", 16'({mode, halt}), 16'h0002);
		req = 8'h04;
		done = 1'b1;
		tick;
		done = 1'b0;
		check("idle entry", 16'({mode, halt, cm}), 16'h0505);
		check("idle clock request", 16'(br), 16'h00FE);
		req = 8'h00;
		irq = 1'b1;
		tick;
		irq = 1'b0;
		check("idle irq", 16'({mode, halt, svc, lpa}), 16'h0003);
		tick;
		check("service pulse", 16'(svc), 16'h0000);
		data = 8'h00;
		wr = 1'b1;
		tick;
		wr = 1'b0;
		tick;
		check("normal active", 16'({br, lpa}), 16'h01FE);
	endtask
	task automatic t_idle_reset;
		data = 8'h33;
		wr = 1'b1;
		idl = 1'b1;
		done = 1'b1;
		tick;
		wr = 1'b0;
		idl = 1'b0;
		done = 1'b0;
		check("idle in low power", 16'({mode, lpa}), 16'h0005);
		nrst = 1'b0;
		tick;
		nrst = 1'b1;
		tick;
		check("reset from idle", 16'({mode, halt}), 16'h0000);
		check("reset ends low power", 16'({cm, lpa}), 16'h0000);
		check("reset vector", vec, 16'h0000);
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			bad_count++;
			test_done;
		end
	end
	initial
	begin
		repeat (10) tick;
		nrst = 1'b1;
		tick;
		t_suspend;
		t_sleep;
		t_idle;
		t_idle_reset;
		test_done;
	end
endmodule // low_power_mode_controller_bench
`default_nettype wire
